/* pkg/pcsa_regs.svh */
// register offsets, field positions and timing counts
// assumes an apb slave with 32-bit data and byte addresses
//
// Notes on behaviour
// R1: video bypass enable floats card address lines 25 to 4.
// R2: card address lines 3 to 0 stay driven during video bypass.
// R3: video bypass select output is low while bypass is enabled.
// R4: video bypass status output is high while bypass is enabled.
// R5: each 32-bit fetch serves two 16-bit card reads and keeps the upper half for the second.
// R6: ring oscillator runs only when system control bit 27 is set.
// R7: power-down and interrogation can run from the ring oscillator.
// R8: in 16-bit io mode battery detect 2 becomes the card speaker input.
// R9: speaker output follows card speaker or cardbus audio input.
// R10: speaker output driven only when speaker enable bit 1 is set.
// R11: pwm route bit 2 sends cardbus pwm audio to the pwm output.
// R12: activity led can be routed to any multifunction pin.
// R13: activity led pulses high for 64 ms, low otherwise.
// R14: activity counts only when card inserted, powered, out of reset.
// R15: 16-bit card activity is ready/irq input low.
// R16: cardbus activity is frame, initiator ready or request active.
// R17: led forced off in suspend, clock stop request, or d1/d2.
// R18: new activity restarts the 64 ms period.
// R19: vcc and vpp select outputs control the external power switch.
// R20: led period count derives from clock rate by a parameter.
// R21: vcc and vpp select codes sit in software-written registers.
`ifndef PCSA_REGS_SVH
`define PCSA_REGS_SVH

`define PCSA_CARD_CTRL_OFS 12'h090
`define PCSA_SYS_CTRL_OFS 12'h080
`define PCSA_MF_ROUTE_OFS 12'h08C
`define PCSA_POWER_OFS 12'h0A0
`define PCSA_STATUS_OFS 12'h0A4
`define PCSA_PREFETCH_OFS 12'h0A8

`define PCSA_CC_CARD_SPEAKER_IN_EN_BIT 1
`define PCSA_CC_PWM_ROUTE_BIT 2
`define PCSA_CC_VIDEO_BIT 6
`define PCSA_SC_RING_OSC_BIT 27

`define PCSA_LED_PERIOD_MS 64
`define PCSA_CLK_HZ 40000000

`endif

/* pkg/pcsa_pkg.sv */
// types shared by the socket auxiliary logic
package pcsa_pkg;
    typedef enum logic [1:0] {
        PCSA_PF_EMPTY,
        PCSA_PF_HELD
    } pcsa_pf_e;
    typedef logic [3:0] pcsa_sel_t;
endpackage : pcsa_pkg

/* design/pcsa_socket_aux.sv */
// socket auxiliary signals: video bypass, audio, led, power select, prefetch
// assumes apb master on pclk; card pins arrive asynchronously
//
// Decided for this implementation: the APB register port and the register addresses.
`include "pcsa_regs.svh"
`timescale 1ns/1ps
module pcsa_socket_aux #(
    parameter int LED_CYCLES = (`PCSA_CLK_HZ / 1000) * `PCSA_LED_PERIOD_MS,
    parameter int MF_PINS = 7
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // card socket inputs
    input wire logic card_inserted,
    input wire logic card_powered,
    input wire logic card_in_reset,
    input wire logic card_is_cardbus,
    input wire logic card_io_mode,
    input wire logic battery_detect_2,
    input wire logic cardbus_audio_in,
    input wire logic card_ready_irq,
    input wire logic cb_frame_n,
    input wire logic cb_initiator_ready_n,
    input wire logic cb_request_n,
    // power management
    input wire logic suspend_n,
    input wire logic clk_stop_pending,
    input wire logic pm_low_state,
    // card address out
    input wire logic [25:0] card_addr_in,
    output logic [25:0] card_addr_out,
    output logic [25:0] card_addr_oe,
    // dma prefetch: 32-bit pci word in, 16-bit card words out
    input wire logic dma_word_valid,
    input wire logic [31:0] dma_word,
    output logic dma_need_fetch,
    input wire logic card_half_take,
    output logic [15:0] card_half_data,
    output logic card_half_valid,
    // video bypass and audio
    output logic video_bypass_select_n,
    output logic video_bypass_status_out,
    output logic system_speaker_out,
    output logic pwm_audio_out,
    output logic socket_activity_led,
    output logic [MF_PINS-1:0] multifunction_pin,
    // power switch and oscillator
    output logic [3:0] vcc_select_out,
    output logic [3:0] vpp_select_out,
    output logic ring_osc_enable
);

    // route register holds eight 4-bit selectors at most
    generate
        if (LED_CYCLES < 2 || MF_PINS < 1 || MF_PINS > 8) begin : g_bad_params
            $error("pcsa_socket_aux: unsupported parameters");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // input synchronisers: three flops, change once stages 2 and 3 agree
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
    assign raw_in = {battery_detect_2, cardbus_audio_in, card_ready_irq, cb_frame_n,
                     cb_initiator_ready_n, cb_request_n, suspend_n, 1'b1};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 8'hFF;
            s2_reg <= 8'hFF;
            s3_reg <= 8'hFF;
        end else begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    clean_reg[gi] <= 1'b1;
                end else if (s2_reg[gi] == s3_reg[gi]) begin
                    clean_reg[gi] <= s3_reg[gi];
                end
            end
        end
    endgenerate

    logic battery_detect_2_s, caud_s, ready_s, frame_n_s, irdy_n_s, req_n_s, suspend_n_s;
    assign {battery_detect_2_s, caud_s, ready_s, frame_n_s, irdy_n_s, req_n_s, suspend_n_s} =
        clean_reg[7:1];

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] card_ctrl_reg;
    logic [31:0] sys_ctrl_reg;
    logic [31:0] mf_route_reg;
    pcsa_pkg::pcsa_sel_t vcc_sel_reg;
    pcsa_pkg::pcsa_sel_t vpp_sel_reg;
    logic [31:0] prefetch_count_reg;

    logic wr_en, rd_en;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `PCSA_CARD_CTRL_OFS) || (a == `PCSA_SYS_CTRL_OFS) ||
                    (a == `PCSA_MF_ROUTE_OFS) || (a == `PCSA_POWER_OFS) ||
                    (a == `PCSA_STATUS_OFS) || (a == `PCSA_PREFETCH_OFS);
    endfunction : is_mapped

    assign pslverr = psel && penable && !is_mapped(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_ctrl_reg <= 8'h00;
            sys_ctrl_reg <= 32'h00000000;
            mf_route_reg <= 32'h00000000;
            vcc_sel_reg <= 4'h0;
            vpp_sel_reg <= 4'h0;
        end else if (wr_en) begin
            if (paddr == `PCSA_CARD_CTRL_OFS) begin
                card_ctrl_reg <= pwdata[7:0];
            end else if (paddr == `PCSA_SYS_CTRL_OFS) begin
                sys_ctrl_reg <= pwdata;
            end else if (paddr == `PCSA_MF_ROUTE_OFS) begin
                mf_route_reg <= pwdata;
            end else if (paddr == `PCSA_POWER_OFS) begin
                vcc_sel_reg <= pwdata[3:0]; // R21
                vpp_sel_reg <= pwdata[7:4]; // R21
            end
        end
    end

    logic video_en, card_speaker_in_en, pwm_route;
    assign video_en = card_ctrl_reg[`PCSA_CC_VIDEO_BIT];
    assign card_speaker_in_en = card_ctrl_reg[`PCSA_CC_CARD_SPEAKER_IN_EN_BIT];
    assign pwm_route = card_ctrl_reg[`PCSA_CC_PWM_ROUTE_BIT];

    ////////////////////////////////////////////////////////////////////
    // video bypass and card address drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_addr_out <= 26'h0;
        end else begin
            card_addr_out <= card_addr_in;
        end
    end

    assign card_addr_oe[3:0] = 4'hF; // R2
    assign card_addr_oe[25:4] = video_en ? 22'h000000 : 22'h3FFFFF; // R1
    assign video_bypass_select_n = !video_en; // R3
    assign video_bypass_status_out = video_en; // R4

    ////////////////////////////////////////////////////////////////////
    // audio
    logic card_speaker_in_src;
    assign card_speaker_in_src = card_is_cardbus ? caud_s : (card_io_mode & battery_detect_2_s); // R8 R9
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_speaker_out <= 1'b0;
            pwm_audio_out <= 1'b0;
        end else begin
            system_speaker_out <= card_speaker_in_en & card_speaker_in_src; // R10
            pwm_audio_out <= pwm_route & card_is_cardbus & caud_s; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////
    // activity led
    logic card_live, activity, led_kill;
    logic [31:0] led_cnt_reg;
    assign card_live = card_inserted && card_powered && !card_in_reset; // R14
    assign activity = card_live && (card_is_cardbus ?
        (!frame_n_s || !irdy_n_s || !req_n_s) : // R16
        !ready_s); // R15
    assign led_kill = !suspend_n_s || clk_stop_pending || pm_low_state; // R17

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_cnt_reg <= 32'h00000000;
        end else if (led_kill) begin
            led_cnt_reg <= 32'h00000000; // R17
        end else if (activity) begin
            led_cnt_reg <= 32'(LED_CYCLES); // R18 R20
        end else if (led_cnt_reg != 32'h00000000) begin
            led_cnt_reg <= led_cnt_reg - 32'h00000001; // R13
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            socket_activity_led <= 1'b0;
        end else begin
            socket_activity_led <= !led_kill && (activity || led_cnt_reg > 32'h00000001);
        end
    end

    generate
        for (gi = 0; gi < MF_PINS; gi++) begin : g_mf
            // 4-bit selector per pin, code 1 = led, 2 = status, 3 = select, 4 = pwm
            always_comb begin
                case (mf_route_reg[gi*4 +: 4])
                    4'h1: multifunction_pin[gi] = socket_activity_led; // R12
                    4'h2: multifunction_pin[gi] = video_bypass_status_out;
                    4'h3: multifunction_pin[gi] = video_bypass_select_n;
                    4'h4: multifunction_pin[gi] = pwm_audio_out;
                    default: multifunction_pin[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // power switch and ring oscillator enable
    assign vcc_select_out = vcc_sel_reg; // R19
    assign vpp_select_out = vpp_sel_reg; // R19
    // oscillator clock lets power-down logic run without pclk
    assign ring_osc_enable = sys_ctrl_reg[`PCSA_SC_RING_OSC_BIT]; // R6 R7

    ////////////////////////////////////////////////////////////////////
    // dma prefetch: one 32-bit fetch serves two 16-bit card transfers
    pcsa_pkg::pcsa_pf_e pf_state;
    logic [15:0] pf_upper_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_state <= pcsa_pkg::PCSA_PF_EMPTY;
            card_half_data <= 16'h0000;
            card_half_valid <= 1'b0;
            pf_upper_reg <= 16'h0000;
            prefetch_count_reg <= 32'h00000000;
        end else begin
            case (pf_state)
                pcsa_pkg::PCSA_PF_EMPTY: begin
                    if (card_half_valid && card_half_take) begin
                        card_half_valid <= 1'b0;
                    end else if (!card_half_valid && dma_word_valid) begin
                        card_half_data <= dma_word[15:0]; // R5
                        pf_upper_reg <= dma_word[31:16]; // R5
                        card_half_valid <= 1'b1;
                        prefetch_count_reg <= prefetch_count_reg + 32'h00000001;
                        pf_state <= pcsa_pkg::PCSA_PF_HELD;
                    end
                end
                pcsa_pkg::PCSA_PF_HELD: begin
                    if (card_half_take) begin
                        card_half_data <= pf_upper_reg; // R5
                        pf_state <= pcsa_pkg::PCSA_PF_EMPTY;
                    end
                end
                default: pf_state <= pcsa_pkg::PCSA_PF_EMPTY;
            endcase
        end
    end
    assign dma_need_fetch = (pf_state == pcsa_pkg::PCSA_PF_EMPTY) && !card_half_valid;

    ////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        prdata = 32'h00000000;
        if (rd_en) begin
            if (paddr == `PCSA_CARD_CTRL_OFS) begin
                prdata = {24'h000000, card_ctrl_reg};
            end else if (paddr == `PCSA_SYS_CTRL_OFS) begin
                prdata = sys_ctrl_reg;
            end else if (paddr == `PCSA_MF_ROUTE_OFS) begin
                prdata = mf_route_reg;
            end else if (paddr == `PCSA_POWER_OFS) begin
                prdata = {24'h000000, vpp_sel_reg, vcc_sel_reg};
            end else if (paddr == `PCSA_STATUS_OFS) begin
                prdata = {27'h0, pf_state == pcsa_pkg::PCSA_PF_HELD,
                          card_live, socket_activity_led, video_en, system_speaker_out};
            end else if (paddr == `PCSA_PREFETCH_OFS) begin
                prdata = prefetch_count_reg;
            end
        end
    end

endmodule : pcsa_socket_aux

/* bench/pcsa_socket_aux_props.sv */
// checker: video bypass pins, prefetch handshake, activity led
// assumes bind onto pcsa_socket_aux, single pclk domain
`timescale 1ns/1ps
module pcsa_socket_aux_props #(
    parameter int LED_CYCLES = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // inputs watched
    input wire logic card_inserted,
    input wire logic clk_stop_pending,
    input wire logic pm_low_state,
    input wire logic suspend_n,
    input wire logic dma_word_valid,
    input wire logic [31:0] dma_word,
    // outputs watched
    input wire logic [25:0] card_addr_oe,
    input wire logic dma_need_fetch,
    input wire logic [15:0] card_half_data,
    input wire logic card_half_valid,
    input wire logic video_bypass_select_n,
    input wire logic video_bypass_status_out,
    input wire logic socket_activity_led
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] hi_cnt;
    // length of the current led high run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt <= 32'h0;
        end else begin
            hi_cnt <= socket_activity_led ? hi_cnt + 32'h1 : 32'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_oe_low; card_addr_oe[3:0] == 4'hF; endproperty
    a_oe_low: assert property (p_oe_low) else $error("low address lines floated");
    property p_oe_hi; card_addr_oe[25:4] == {22{!video_bypass_status_out}}; endproperty
    a_oe_hi: assert property (p_oe_hi) else $error("upper address enables wrong");
    property p_sel; video_bypass_select_n != video_bypass_status_out; endproperty
    a_sel: assert property (p_sel) else $error("bypass select and status agree");
    property p_kill; pm_low_state || clk_stop_pending |=> !socket_activity_led; endproperty
    a_kill: assert property (p_kill) else $error("led on while stopped");
    property p_dead; !card_inserted && !socket_activity_led |=> !socket_activity_led; endproperty
    a_dead: assert property (p_dead) else $error("led lit with no card");
    property p_fetch;
        dma_need_fetch && dma_word_valid |=> card_half_valid &&
            {16'h0, card_half_data} == ($past(dma_word) & 32'h0000FFFF);
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetched low half wrong");
    property p_need; card_half_valid |-> !dma_need_fetch; endproperty
    a_need: assert property (p_need) else $error("fetch asked with half held");
    property p_led_len;
        $fell(socket_activity_led) && hi_cnt != 0 && !$past(pm_low_state) &&
            !$past(clk_stop_pending) && $past(suspend_n) |-> hi_cnt >= LED_CYCLES - 2;
    endproperty
    a_led_len: assert property (p_led_len) else $error("led pulse too short");
endmodule : pcsa_socket_aux_props

/* bench/pcsa_card_model.sv */
// card pins and dma word source seen from the socket
// assumes bench holds act and feed for whole cycles
`timescale 1ns/1ps
module pcsa_card_model (
    // clock
    input wire logic pclk,
    // bench control
    input wire logic [2:0] act,
    input wire logic aud,
    input wire logic feed,
    // card pins
    output logic card_ready_irq,
    output logic cb_frame_n,
    output logic cb_initiator_ready_n,
    output logic cb_request_n,
    output logic battery_detect_2,
    output logic cardbus_audio_in,
    // dma source
    input wire logic dma_need_fetch,
    output logic dma_word_valid,
    output logic [31:0] dma_word
);
    logic [15:0] n = 16'h0;
    assign card_ready_irq = !act[0];
    assign cb_frame_n = !act[0];
    assign cb_initiator_ready_n = !act[1];
    assign cb_request_n = !act[2];
    // one terminal carries both audio kinds
    assign battery_detect_2 = aud;
    assign cardbus_audio_in = aud;
    assign dma_word_valid = feed;
    // idle bus shows the inverse pattern
    assign dma_word = feed ? {n, ~n} : {~n, n};
    always @(posedge pclk) begin
        if (feed && dma_need_fetch) begin
            n <= n + 16'h1;
        end
    end
endmodule : pcsa_card_model

/* bench/pcsa_socket_aux_tb.sv */
// bench: apb, card pins and dma source around the socket aux block
// assumes pcsa_regs.svh on the include path
`timescale 1ns/1ps
`include "pcsa_regs.svh"
module pcsa_socket_aux_tb;
    localparam int LEDC = 20;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, dma_word;
    logic pready, pslverr, er, card_inserted = 1'b1, card_powered = 1'b1, card_in_reset = 1'b0;
    logic card_is_cardbus = 1'b0, card_io_mode = 1'b0, suspend_n = 1'b1, clk_stop_pending = 1'b0;
    logic pm_low_state = 1'b0, card_half_take = 1'b0, aud = 1'b0, feed = 1'b0;
    logic [2:0] act = 3'h0;
    logic [25:0] card_addr_in = 26'h0, card_addr_out, card_addr_oe;
    logic battery_detect_2, cardbus_audio_in, card_ready_irq, cb_frame_n, cb_initiator_ready_n;
    logic cb_request_n, dma_word_valid, dma_need_fetch, card_half_valid, ring_osc_enable;
    logic video_bypass_select_n, video_bypass_status_out, system_speaker_out, pwm_audio_out;
    logic socket_activity_led;
    logic [15:0] card_half_data, nn = 16'h0;
    logic [6:0] multifunction_pin;
    logic [3:0] vcc_select_out, vpp_select_out;
    logic [7:0] lf = 8'h54;
    // {pwm route, speaker en, cardbus, io mode, speaker, pwm}
    logic [5:0] tab [5] = '{6'h16, 6'h10, 6'h1A, 6'h29, 6'h04};
    int fail_count = 0, n_compared = 0, cyc = 0, n, i;
    pcsa_socket_aux #(.LED_CYCLES(LEDC), .MF_PINS(7)) u_pcsa_socket_aux (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .card_inserted,
        .card_powered, .card_in_reset, .card_is_cardbus, .card_io_mode, .battery_detect_2,
        .cardbus_audio_in, .card_ready_irq, .cb_frame_n, .cb_initiator_ready_n, .cb_request_n,
        .suspend_n, .clk_stop_pending, .pm_low_state, .card_addr_in, .card_addr_out,
        .card_addr_oe, .dma_word_valid, .dma_word, .dma_need_fetch, .card_half_take,
        .card_half_data, .card_half_valid, .video_bypass_select_n, .video_bypass_status_out,
        .system_speaker_out, .pwm_audio_out, .socket_activity_led, .multifunction_pin,
        .vcc_select_out, .vpp_select_out, .ring_osc_enable);
    pcsa_card_model u_pcsa_card_model (.pclk, .act, .aud, .feed, .card_ready_irq, .cb_frame_n,
        .cb_initiator_ready_n, .cb_request_n, .battery_detect_2, .cardbus_audio_in,
        .dma_need_fetch, .dma_word_valid, .dma_word);
    always #12.5 pclk = ~pclk;
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
    endtask : wt
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        wt(1);
        penable <= 1'b1;
        wt(1);
        while (pready !== 1'b1) wt(1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        wt(1);
    endtask : apb
    task automatic kick(input logic [2:0] s);
        fork
            begin
                act <= s;
                wt(3);
                act <= 3'h0;
            end
        join_none
    endtask : kick
    task automatic hi(output int len);
        len = 0;
        while (socket_activity_led !== 1'b1) wt(1);
        chk(multifunction_pin[0], 1'b1);
        while (socket_activity_led === 1'b1) begin
            wt(1);
            len++;
        end
    endtask : hi
    task automatic take();
        card_half_take <= 1'b1;
        wt(1);
        card_half_take <= 1'b0;
        wt(1);
    endtask : take
    initial begin
        wt(16);
        presetn <= 1'b1;
        wt(1);
        chk({ring_osc_enable, video_bypass_select_n, card_addr_oe}, {2'b01, 26'h3FFFFFF});
        apb(1'b1, `PCSA_MF_ROUTE_OFS, 32'h21);
        apb(1'b1, `PCSA_CARD_CTRL_OFS, 32'h40);
        chk({video_bypass_select_n, video_bypass_status_out, multifunction_pin[1], card_addr_oe},
            {3'b011, 22'h0, 4'hF});
        apb(1'b0, `PCSA_CARD_CTRL_OFS, 32'h0);
        chk(rd, 32'h40);
        card_addr_in <= {lf, lf, lf, lf[1:0]};
        wt(2);
        chk(card_addr_out, card_addr_in);
        apb(1'b1, `PCSA_SYS_CTRL_OFS, 32'h0800_0000);
        chk(ring_osc_enable, 1'b1);
        for (i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            apb(1'b1, `PCSA_POWER_OFS, {24'h0, lf});
            chk({vpp_select_out, vcc_select_out}, lf);
        end
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        chk(er, 1'b1);
        for (i = 0; i < 5; i++) begin
            apb(1'b1, `PCSA_CARD_CTRL_OFS, {29'h0, tab[i][5:4], 1'b0});
            card_is_cardbus <= tab[i][3];
            card_io_mode <= tab[i][2];
            aud <= 1'b1;
            wt(8);
            chk({system_speaker_out, pwm_audio_out}, tab[i][1:0]);
            aud <= 1'b0;
            wt(8);
            chk({system_speaker_out, pwm_audio_out}, 2'b00);
        end
        // ready, then frame, initiator ready, request; last one retriggered
        for (i = 0; i < 4; i++) begin
            card_is_cardbus <= (i > 0);
            kick(i == 0 ? 3'h1 : 3'h1 << (i - 1));
            if (i == 3) begin
                fork
                    begin
                        wt(14);
                        kick(3'h4);
                    end
                join_none
            end
            hi(n);
            chk(n >= LEDC && n <= (i == 3 ? 3 * LEDC : LEDC + 6) && (i < 3 || n > LEDC + 10),
                1'b1);
            wt(4);
        end
        kick(3'h1);
        wt(10);
        pm_low_state <= 1'b1;
        wt(30);
        chk(socket_activity_led, 1'b0);
        pm_low_state <= 1'b0;
        wt(2);
        kick(3'h1);
        wt(10);
        clk_stop_pending <= 1'b1;
        wt(3);
        chk(socket_activity_led, 1'b0);
        clk_stop_pending <= 1'b0;
        wt(2);
        kick(3'h1);
        wt(10);
        suspend_n <= 1'b0;
        wt(8);
        chk(socket_activity_led, 1'b0);
        suspend_n <= 1'b1;
        wt(8);
        for (i = 0; i < 2; i++) begin
            card_inserted <= (i != 0);
            card_powered <= (i == 0);
            kick(3'h7);
            wt(12);
            chk(socket_activity_led, 1'b0);
        end
        for (i = 0; i < 2; i++) begin
            feed <= 1'b1;
            while (card_half_valid !== 1'b1) wt(1);
            feed <= 1'b0;
            chk({dma_need_fetch, card_half_data}, {1'b0, ~nn});
            take();
            chk(card_half_data, nn);
            take();
            chk(card_half_valid, 1'b0);
            nn++;
        end
        apb(1'b0, `PCSA_PREFETCH_OFS, 32'h0);
        chk(rd, 32'h2);
        test_done();
    end
endmodule : pcsa_socket_aux_tb
bind pcsa_socket_aux pcsa_socket_aux_props #(.LED_CYCLES(LED_CYCLES)) u_pcsa_socket_aux_props (
    .pclk, .presetn, .card_inserted, .clk_stop_pending, .pm_low_state, .suspend_n, .dma_word_valid,
    .dma_word, .card_addr_oe, .dma_need_fetch, .card_half_data, .card_half_valid,
    .video_bypass_select_n, .video_bypass_status_out, .socket_activity_led);
